/* File: aar_pkg.sv */
package aar_pkg;

    // Management frame fields
    localparam logic [1:0]  AAR_OP_READ       = 2'h2;
    localparam logic [1:0]  AAR_OP_WRITE      = 2'h1;
    localparam logic [4:0]  AAR_OP_LAST       = 5'h02;
    localparam logic [4:0]  AAR_ADDR_LAST     = 5'h09;
    localparam logic [4:0]  AAR_TURN_LAST     = 5'h01;
    localparam logic [4:0]  AAR_DATA_LAST     = 5'h0F;
    localparam int          AAR_PREAMBLE_LEN  = 32;

    // Register addresses
    localparam logic [4:0]  AAR_ADDR_ADV      = 5'h04;
    localparam logic [4:0]  AAR_ADDR_PARTNER  = 5'h05;

    // Shared field layout of both ability words
    localparam int          AAR_SEL_LSB       = 0;
    localparam int          AAR_SEL_W         = 5;
    localparam int          AAR_TECH_LSB      = 5;
    localparam int          AAR_TECH_W        = 5;
    localparam int          AAR_STRAP_W       = 4;
    localparam int          AAR_BIT_PAUSE     = 10;
    localparam int          AAR_BIT_ASYM      = 11;
    localparam int          AAR_BIT_RSVD      = 12;
    localparam int          AAR_BIT_RFAULT    = 13;
    localparam int          AAR_BIT_ACK       = 14;
    localparam int          AAR_BIT_NPAGE     = 15;

    // Values
    localparam logic [4:0]  AAR_SEL_8023      = 5'h01;
    localparam logic [15:0] AAR_ADV_WR_MASK   = 16'hAFFF;
    localparam logic [15:0] AAR_PARTNER_MASK  = 16'hEFFF;
    localparam logic [15:0] AAR_PARTNER_RESET = 16'h0000;
    localparam int          AAR_MATCH_COUNT   = 3;
    localparam logic [1:0]  AAR_STRAP_DELAY   = 2'h3;

    typedef enum logic [2:0] {
        AAR_S_IDLE = 3'h0,
        AAR_S_OP   = 3'h1,
        AAR_S_ADDR = 3'h3,
        AAR_S_TURN = 3'h2,
        AAR_S_DATA = 3'h6
    } aar_state_t;

endpackage

/* File: aar_sync2.sv */
module aar_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule // aar_sync2

/* File: aar_match.sv */
module aar_match #(
    parameter int W = 16,
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clear,
    input  wire logic         wordValid,
    input  wire logic [W-1:0] word,
    output logic              loadPulse,
    output logic      [W-1:0] loadWord
);

    localparam int CW = $clog2(N + 1);
    localparam logic [CW-1:0] ONE  = CW'(1);
    localparam logic [CW-1:0] LAST = CW'(N - 1);

    logic [CW-1:0] count_reg;
    logic [W-1:0]  last_reg;
    logic          same;

    assign same = (count_reg != '0) && (word == last_reg);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            last_reg  <= '0;
            loadPulse <= 1'b0;
            loadWord  <= '0;
        end else begin
            loadPulse <= 1'b0;
            if (clear) begin
                count_reg <= '0;
            end else if (wordValid) begin
                last_reg <= word;
                if (!same) begin
                    count_reg <= ONE;
                end else if (count_reg == LAST) begin
                    // Fires once per run of identical words; longer runs do not reload
                    count_reg <= count_reg + ONE;
                    loadPulse <= 1'b1;
                    loadWord  <= word;
                end else if (count_reg < LAST) begin
                    count_reg <= count_reg + ONE;
                end
            end
        end
    end

endmodule // aar_match

/* File: aar_ability_regs.sv */
module aar_ability_regs
    import aar_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR      = 5'h00,
    parameter bit         HAS_PAUSE_PIN = 1'b1,
    parameter int         PREAMBLE_LEN  = AAR_PREAMBLE_LEN
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        mdc,
    input  wire logic        mdioIn,
    output logic             mdioOut,
    output logic             mdioOe,
    input  wire logic        pausePin,
    input  wire logic [3:0]  cfgPins,
    input  wire logic        codeTxStart,
    input  wire logic        rxWordValid,
    input  wire logic [15:0] rxWord,
    input  wire logic        fullDuplexResolved,
    output logic [15:0]      advertisedWord,
    output logic [15:0]      partnerWord,
    output logic             remoteFaultStatus,
    output logic             pauseEnable
);

    localparam logic [5:0] ONES_MAX = 6'(PREAMBLE_LEN);

    logic             mdcS;
    logic             mdioS;
    logic             pauseS;
    logic [3:0]       cfgS;
    logic             mdcPrev_reg;
    logic             mdcRise;

    aar_state_t       state_reg;
    logic [4:0]       bitCnt_reg;
    logic [5:0]       onesCnt_reg;
    logic [15:0]      shift_reg;
    logic             isRead_reg;
    logic             phyMatch_reg;
    logic [4:0]       regAddr_reg;
    logic [15:0]      outShift_reg;
    logic [1:0]       strapCnt_reg;

    logic             wrStrobe;
    logic [15:0]      wrData;
    logic             owned;
    logic [15:0]      readWord;
    logic             loadPulse;
    logic [15:0]      loadWord;
    logic [15:0]      strapDefault;

    // Pins come from outside the clock domain
    aar_sync2 #(.WIDTH(7)) u_sync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn ({mdc, mdioIn, pausePin, cfgPins}),
        .syncOut ({mdcS, mdioS, pauseS, cfgS})
    );

    aar_match #(.W(16), .N(AAR_MATCH_COUNT)) u_match (
        .clk       (clk),
        .reset     (reset),
        .clear     (codeTxStart),
        .wordValid (rxWordValid),
        .word      (rxWord),
        .loadPulse (loadPulse),
        .loadWord  (loadWord)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mdcPrev_reg <= 1'b0;
        end else begin
            mdcPrev_reg <= mdcS;
        end
    end

    assign mdcRise = mdcS & ~mdcPrev_reg;

    // Management frame decoder, one step per rising management clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg    <= AAR_S_IDLE;
            bitCnt_reg   <= '0;
            onesCnt_reg  <= '0;
            shift_reg    <= '0;
            isRead_reg   <= 1'b0;
            phyMatch_reg <= 1'b0;
            regAddr_reg  <= '0;
        end else if (mdcRise) begin
            shift_reg  <= {shift_reg[14:0], mdioS};
            bitCnt_reg <= bitCnt_reg + 5'h01;
            case (state_reg)
                AAR_S_IDLE: begin
                    bitCnt_reg <= '0;
                    if (mdioS) begin
                        if (onesCnt_reg < ONES_MAX) begin
                            onesCnt_reg <= onesCnt_reg + 6'h01;
                        end
                    end else begin
                        // A zero after a full preamble is the first start bit
                        if (onesCnt_reg >= ONES_MAX) begin
                            state_reg <= AAR_S_OP;
                        end
                        onesCnt_reg <= '0;
                    end
                end
                AAR_S_OP: begin
                    if (bitCnt_reg == AAR_OP_LAST) begin
                        bitCnt_reg <= '0;
                        isRead_reg <= ({shift_reg[0], mdioS} == AAR_OP_READ);
                        if (shift_reg[1] && ({shift_reg[0], mdioS} == AAR_OP_READ
                                             || {shift_reg[0], mdioS} == AAR_OP_WRITE)) begin
                            state_reg <= AAR_S_ADDR;
                        end else begin
                            state_reg <= AAR_S_IDLE;
                        end
                    end
                end
                AAR_S_ADDR: begin
                    if (bitCnt_reg == AAR_ADDR_LAST) begin
                        bitCnt_reg   <= '0;
                        phyMatch_reg <= (shift_reg[8:4] == PHY_ADDR);
                        regAddr_reg  <= {shift_reg[3:0], mdioS};
                        state_reg    <= AAR_S_TURN;
                    end
                end
                AAR_S_TURN: begin
                    if (bitCnt_reg == AAR_TURN_LAST) begin
                        bitCnt_reg <= '0;
                        state_reg  <= AAR_S_DATA;
                    end
                end
                AAR_S_DATA: begin
                    if (bitCnt_reg == AAR_DATA_LAST) begin
                        bitCnt_reg <= '0;
                        state_reg  <= AAR_S_IDLE;
                    end
                end
                default: begin
                    state_reg <= AAR_S_IDLE;
                end
            endcase
        end
    end

    assign wrData   = {shift_reg[14:0], mdioS};
    assign wrStrobe = mdcRise && (state_reg == AAR_S_DATA) && (bitCnt_reg == AAR_DATA_LAST)
                      && !isRead_reg && phyMatch_reg;
    assign owned    = (regAddr_reg == AAR_ADDR_ADV) || (regAddr_reg == AAR_ADDR_PARTNER);

    always_comb begin
        readWord = '0;
        if (regAddr_reg == AAR_ADDR_ADV) begin
            readWord = advertisedWord;
        end else if (regAddr_reg == AAR_ADDR_PARTNER) begin
            readWord = partnerWord & AAR_PARTNER_MASK;
        end
    end

    // Read data turnaround and shift out; other addresses are left to other blocks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mdioOut      <= 1'b0;
            mdioOe       <= 1'b0;
            outShift_reg <= '0;
        end else if (mdcRise) begin
            if (state_reg == AAR_S_TURN && bitCnt_reg == '0) begin
                mdioOut <= 1'b0;
                mdioOe  <= isRead_reg && phyMatch_reg && owned;
            end else if (state_reg == AAR_S_TURN) begin
                mdioOut      <= readWord[15];
                outShift_reg <= {readWord[14:0], 1'b0};
            end else if (state_reg == AAR_S_DATA && bitCnt_reg != AAR_DATA_LAST) begin
                mdioOut      <= outShift_reg[15];
                outShift_reg <= {outShift_reg[14:0], 1'b0};
            end else begin
                mdioOut <= 1'b0;
                mdioOe  <= 1'b0;
            end
        end
    end

    // Straps are caught once the synchronisers hold settled pin levels
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strapCnt_reg <= '0;
        end else if (strapCnt_reg != AAR_STRAP_DELAY) begin
            strapCnt_reg <= strapCnt_reg + 2'h1;
        end
    end

    always_comb begin
        strapDefault = '0;
        strapDefault[AAR_SEL_LSB +: AAR_SEL_W] = AAR_SEL_8023;
        strapDefault[AAR_TECH_LSB +: AAR_STRAP_W] = cfgS;
        strapDefault[AAR_BIT_PAUSE] = HAS_PAUSE_PIN ? pauseS : 1'b0;
    end

    // Local advertisement; only management writes and straps change it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            advertisedWord <= '0;
            advertisedWord[AAR_SEL_LSB +: AAR_SEL_W] <= AAR_SEL_8023;
        end else if (strapCnt_reg == AAR_STRAP_DELAY - 2'h1) begin
            advertisedWord <= strapDefault;
        end else if (wrStrobe && regAddr_reg == AAR_ADDR_ADV) begin
            // Selector is stored as written; keeping codes legal is software's job
            advertisedWord <= wrData & AAR_ADV_WR_MASK;
        end
    end

    // Partner ability; management writes never reach it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            partnerWord <= AAR_PARTNER_RESET;
        end else if (codeTxStart) begin
            partnerWord <= AAR_PARTNER_RESET;
        end else if (loadPulse) begin
            // Bits 15..0 carry next page, ack, fault, pauses, technologies, selector
            partnerWord <= loadWord & AAR_PARTNER_MASK;
        end
    end

    assign remoteFaultStatus = advertisedWord[AAR_BIT_RFAULT];

    // Half duplex never pauses, whatever both ends advertise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pauseEnable <= 1'b0;
        end else begin
            pauseEnable <= fullDuplexResolved && advertisedWord[AAR_BIT_PAUSE]
                           && partnerWord[AAR_BIT_PAUSE];
        end
    end

endmodule // aar_ability_regs

/* File: aar_mdio_ctl.sv */
module aar_mdio_ctl
    import aar_pkg::*;
(
    input  wire logic clk,
    output logic      mdc,
    output logic      mdioIn,
    input  wire logic mdioOut,
    input  wire logic mdioOe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic drv;
    logic val;

    // Pull-up holds the line high whenever nobody drives it
    assign mdioIn = mdioOe ? mdioOut : (drv ? val : 1'b1);

    initial begin
        mdc = 1'b0;
        drv = 1'b0;
        val = 1'b1;
    end

    // Short preamble: the design is built with a two-bit preamble
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [33:0] bits;
        bits = {4'hD, op, 5'h00, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 33; i >= 0; i--) begin
            @(posedge clk);
            mdc <= 1'b0;
            drv <= !(op == AAR_OP_READ && i < 18);
            val <= bits[i];
            repeat (10) @(posedge clk);
            if (i < 16) rd = {rd[14:0], mdioIn};
            mdc <= 1'b1;
            repeat (9) @(posedge clk);
        end
        @(posedge clk);
        mdc <= 1'b0;
        drv <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
endmodule // aar_mdio_ctl

/* File: aar_ability_regs_props.sv */
module aar_ability_regs_props
    import aar_pkg::*;
#(
    parameter bit HAS_PAUSE_PIN = 1'b1
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        mdc,
    input wire logic        pausePin,
    input wire logic [3:0]  cfgPins,
    input wire logic        codeTxStart,
    input wire logic        rxWordValid,
    input wire logic [15:0] rxWord,
    input wire logic        fullDuplexResolved,
    input wire logic [15:0] advertisedWord,
    input wire logic [15:0] partnerWord,
    input wire logic        remoteFaultStatus,
    input wire logic        pauseEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_strap_load_value: assert property ($fell(reset) |-> ##3
        advertisedWord == {5'h00, pausePin & HAS_PAUSE_PIN, 1'b0, cfgPins, AAR_SEL_8023})
        else $error("strap defaults wrong");
    a_fault_status_mirror: assert property (
        remoteFaultStatus == advertisedWord[AAR_BIT_RFAULT]) else $error("fault status mismatch");
    a_fault_write_only: assert property (
        $changed(advertisedWord[AAR_BIT_RFAULT]) |-> $past(mdc, 3)) else $error("fault bit moved");
    a_pause_full_duplex: assert property (
        fullDuplexResolved && advertisedWord[10] && partnerWord[10] |=> pauseEnable)
        else $error("pause not enabled");
    a_pause_half_off: assert property (!fullDuplexResolved |=> !pauseEnable)
        else $error("pause in half duplex");
    a_partner_rsvd_zero: assert property (partnerWord[AAR_BIT_RSVD] == 1'b0)
        else $error("reserved bit set");
    a_partner_clear: assert property (codeTxStart |=> partnerWord == AAR_PARTNER_RESET)
        else $error("partner not cleared");
    a_partner_load: assert property (
        rxWordValid ##1 (rxWordValid && rxWord == $past(rxWord))[*2]
        |-> ##2 partnerWord == ($past(rxWord, 2) & AAR_PARTNER_MASK)) else $error("partner not loaded");
    a_partner_read_only: assert property (
        $changed(partnerWord) |-> $past(rxWordValid, 2) || $past(codeTxStart)) else $error("partner moved");
endmodule // aar_ability_regs_props

bind aar_ability_regs aar_ability_regs_props #(.HAS_PAUSE_PIN(HAS_PAUSE_PIN)) aar_ability_regs_props_i (.*);

/* File: tb.sv */
module tb
    import aar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        reset;
    logic        mdc;
    logic        mdioIn;
    logic        mdioOut;
    logic        mdioOe;
    logic        pausePin;
    logic [3:0]  cfgPins;
    logic        codeTxStart;
    logic        rxWordValid;
    logic [15:0] rxWord;
    logic        fullDuplexResolved;
    logic [15:0] advertisedWord;
    logic [15:0] partnerWord;
    logic        remoteFaultStatus;
    logic        pauseEnable;
    int          errTotal;
    int          totalChecks;

    always #5 clk = ~clk;

    aar_ability_regs #(.PREAMBLE_LEN(2)) aar_ability_regs_i (.clk(clk), .reset(reset), .mdc(mdc),
        .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .pausePin(pausePin), .cfgPins(cfgPins),
        .codeTxStart(codeTxStart), .rxWordValid(rxWordValid), .rxWord(rxWord),
        .fullDuplexResolved(fullDuplexResolved), .advertisedWord(advertisedWord),
        .partnerWord(partnerWord), .remoteFaultStatus(remoteFaultStatus), .pauseEnable(pauseEnable));

    aar_mdio_ctl aar_mdio_ctl_i (.clk(clk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        aar_mdio_ctl_i.frame(AAR_OP_WRITE, a, d, r);
    endtask

    task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
        logic [15:0] r;
        aar_mdio_ctl_i.frame(AAR_OP_READ, a, 16'h0000, r);
        chk(nm, e, r);
    endtask

    task automatic sendw(input logic [15:0] w);
        @(posedge clk);
        rxWordValid <= 1'b1;
        rxWord <= w;
    endtask

    task automatic t_reset();
        repeat (10) @(posedge clk);
        chk("adv reset", 16'h0001, advertisedWord);
        chk("partner reset", 16'h0000, partnerWord);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        chk("adv straps", 16'h0541, advertisedWord);
        rdchk("adv read", AAR_ADDR_ADV, 16'h0541);
        $display("test reset done");
    endtask

    task automatic t_adv();
        wr(AAR_ADDR_ADV, 16'h0002);
        rdchk("sel 802.9", AAR_ADDR_ADV, 16'h0002);
        wr(AAR_ADDR_ADV, 16'hEFE1);
        rdchk("adv masked", AAR_ADDR_ADV, 16'hAFE1);
        chk("fault status", 16'h0001, {15'h0000, remoteFaultStatus});
        rdchk("unmapped", 5'h06, 16'hFFFF);
        $display("test advertisement done");
    endtask

    task automatic t_partner();
        sendw(16'hFFFF);
        sendw(16'hFFFF);
        sendw(16'h4C21);
        sendw(16'hFFFF);
        @(posedge clk);
        rxWordValid <= 1'b0;
        repeat (4) @(posedge clk);
        chk("no early load", 16'h0000, partnerWord);
        // Three back to back words so the load property sees its full run
        sendw(16'hFFFF);
        sendw(16'hFFFF);
        sendw(16'hFFFF);
        @(posedge clk);
        rxWordValid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("partner load", 16'hEFFF, partnerWord);
        wr(AAR_ADDR_PARTNER, 16'h0000);
        rdchk("partner ro", AAR_ADDR_PARTNER, 16'hEFFF);
        chk("fault kept", 16'hAFE1, advertisedWord);
        $display("test partner done");
    endtask

    task automatic t_pause();
        fullDuplexResolved <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pause full", 16'h0001, {15'h0000, pauseEnable});
        fullDuplexResolved <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pause half", 16'h0000, {15'h0000, pauseEnable});
        fullDuplexResolved <= 1'b1;
        codeTxStart <= 1'b1;
        @(posedge clk);
        codeTxStart <= 1'b0;
        repeat (3) @(posedge clk);
        chk("partner clear", 16'h0000, partnerWord);
        chk("pause cleared", 16'h0000, {15'h0000, pauseEnable});
        $display("test pause done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        pausePin = 1'b1;
        cfgPins = 4'hA;
        codeTxStart = 1'b0;
        rxWordValid = 1'b0;
        rxWord = 16'h0000;
        fullDuplexResolved = 1'b0;
        errTotal = 0;
        totalChecks = 0;
        t_reset();
        t_adv();
        t_partner();
        t_pause();
        tally_and_finish();
    end

    // Eight frames of about 700 cycles each fit well inside this span
    initial begin
        repeat (50000) @(posedge clk);
        errTotal++;
        tally_and_finish();
    end
endmodule // tb
